//--- rtl/ssp_core.sv
// synchronous serial port, 8 or 16 bits, LSB first, internal or external clock
// assumes a one-cycle register port with read data one cycle later
`timescale 1ns/1ps
`default_nettype none
module ssp_core #(
  parameter int PRESC_W = ssp_pkg::SSP_PRESC_W
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // serial pins
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOe,
  input wire logic sdiIn,
  output logic sdoOut,
  output logic sdoOe,
  // interrupt request toward the processor
  output logic irqReq
);
  import ssp_pkg::*;
  if (PRESC_W < SSP_NTAPS) begin : g_presc_check
    $error("PRESC_W too small for clock taps");
  end
  // ********************************************
  // pin synchronisers
  // ********************************************
  ssp_if pins ();
  ssp_pin_sync u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .sckIn(sckIn),
    .sdiIn(sdiIn),
    .pins(pins)
  );
  // ********************************************
  // registers
  // ********************************************
  logic [7:0] mode_q;
  logic [7:0] dataLo_q;
  logic [7:0] dataHi_q;
  logic [7:0] port_q;
  logic [7:0] pinsel_q;
  logic [7:0] portc_q;
  logic irqFlag_q;
  logic irqEn_q;
  ssp_state_t state_q;
  logic [4:0] cnt_q;
  logic sckLvl_q;
  logic sckPrev_q;
  logic intRun_q;
  logic [PRESC_W-1:0] presc_q;
  logic [7:0] rdata_q;
  logic sdo_q;
  wire modeWr = regWr && (regAddr == SSP_OFF_MODE);
  wire dummyRd = regRd && (regAddr == SSP_OFF_MODE);
  wire wide = mode_q[SSP_MODE_WIDTH];
  wire [4:0] wordLen = wide ? 5'h10 : 5'h08;
  wire extClk = (mode_q[SSP_MODE_CKSRC +: 4] == SSP_CKSRC_EXT);
  wire pinOut = pinsel_q[SSP_PIN_OUT];
  wire pinIn = pinsel_q[SSP_PIN_IN];
  wire pinClk = pinsel_q[SSP_PIN_CLK];
  wire enNone = !(mode_q[SSP_MODE_ENHI] || mode_q[SSP_MODE_ENLO]);
  // continuous clock mode: only clock pin, enables 00
  wire contClk = pinClk && !pinOut && !pinIn && enNone;
  wire commOn = (pinOut || pinIn || pinClk) && !enNone && pinClk;
  // ********************************************
  // serial clock source
  // ********************************************
  function automatic logic tapSel(input logic [PRESC_W-1:0] p, input logic [3:0] src);
    tapSel = p[src[2:0]];
  endfunction : tapSel
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_q <= '0;
    end else begin
      presc_q <= presc_q + 1'b1;
    end
  end
  logic tapPrev_q;
  wire tapNow = tapSel(presc_q, mode_q[SSP_MODE_CKSRC +: 4]);
  wire tapTick = tapNow && !tapPrev_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tapPrev_q <= 1'b0;
    end else begin
      tapPrev_q <= tapNow;
    end
  end
  // internal clock generator: idle high, one toggle per tap tick
  wire intDrive = !extClk && (contClk || intRun_q);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sckLvl_q <= 1'b1;
    end else if (modeWr) begin
      sckLvl_q <= 1'b1;
    end else if (intDrive && tapTick) begin
      sckLvl_q <= !sckLvl_q;
    end else if (!intDrive) begin
      sckLvl_q <= 1'b1;
    end
  end
  wire sckNow = extClk ? pins.sckSync : sckLvl_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sckPrev_q <= 1'b1;
    end else begin
      sckPrev_q <= sckNow;
    end
  end
  wire sckFall = sckPrev_q && !sckNow;
  wire sckRise = !sckPrev_q && sckNow;
  wire active = commOn && !contClk && (state_q != SSP_START_PEND);
  wire lastBit = (cnt_q == wordLen - 5'h01);
  wire done = active && sckRise && (state_q == SSP_XFER) && lastBit;
  // ********************************************
  // controller
  // ********************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SSP_START_PEND;
    end else if (modeWr) begin
      state_q <= SSP_START_PEND;
    end else begin
      case (state_q)
        SSP_START_PEND: if (dummyRd) state_q <= SSP_CLK_PEND;
        SSP_CLK_PEND: if (active && sckFall) state_q <= SSP_XFER;
        SSP_XFER: if (dummyRd || done) state_q <= SSP_CLK_PEND;
        default: state_q <= SSP_START_PEND;
      endcase
    end
  end
  // internal clock run flag: one word per dummy read
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      intRun_q <= 1'b0;
    end else if (modeWr || done) begin
      intRun_q <= 1'b0;
    end else if (dummyRd && commOn && !extClk && state_q != SSP_START_PEND) begin
      intRun_q <= 1'b1;
    end else if (dummyRd && commOn && !extClk && state_q == SSP_START_PEND) begin
      intRun_q <= 1'b1;
    end
  end
  // bit counter: counts rising edges during transfer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 5'h00;
    end else if (modeWr || dummyRd || done) begin
      cnt_q <= 5'h00;
    end else if (active && sckRise && state_q == SSP_XFER) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end
  // ********************************************
  // shift data path
  // ********************************************
  wire [15:0] shWord = {dataHi_q, dataLo_q};
  wire inBit = pinIn ? pins.sdiSync : 1'b0;
  wire shiftNow = active && sckRise && (state_q == SSP_XFER);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dataLo_q <= 8'h00;
      dataHi_q <= 8'h00;
    end else if (shiftNow) begin
      // rising edge: shift right, sample receive bit at the top of the word
      if (wide) begin
        {dataHi_q, dataLo_q} <= {inBit, shWord[15:1]};
      end else begin
        dataLo_q <= {inBit, dataLo_q[7:1]};
      end
    end else if (regWr && regAddr == SSP_OFF_DATA_LO) begin
      dataLo_q <= regWdata;
    end else if (regWr && regAddr == SSP_OFF_DATA_HI) begin
      dataHi_q <= regWdata;
    end
  end
  // data out: bit0 driven from falling edge; last bit held in port bit 7
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_q <= 8'h00;
    end else if (active && sckFall && state_q != SSP_START_PEND) begin
      port_q[SSP_PORT_IDLE] <= dataLo_q[0];
    end else if (regWr && regAddr == SSP_OFF_PORT) begin
      port_q <= regWdata;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sdo_q <= 1'b0;
    end else begin
      sdo_q <= port_q[SSP_PORT_IDLE];
    end
  end
  // ********************************************
  // interrupt flag
  // ********************************************
  wire xferExit = (state_q == SSP_XFER) && (modeWr || dummyRd || done);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqFlag_q <= 1'b0;
    end else if (xferExit) begin
      irqFlag_q <= 1'b1;
    end else if (regWr && regAddr == SSP_OFF_IRQ) begin
      irqFlag_q <= regWdata[SSP_IRQ_BIT];
    end
  end
  assign irqReq = irqFlag_q && irqEn_q;
  // ********************************************
  // configuration registers and read port
  // ********************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= SSP_RST_MODE;
      pinsel_q <= SSP_RST_PINSEL;
      portc_q <= SSP_RST_PORTC;
      irqEn_q <= 1'b0;
    end else if (regWr) begin
      case (regAddr)
        SSP_OFF_MODE: mode_q <= regWdata;
        SSP_OFF_PINSEL: pinsel_q <= regWdata;
        SSP_OFF_PORTC: portc_q <= regWdata;
        SSP_OFF_IEN: irqEn_q <= regWdata[SSP_IRQ_BIT];
        default: ;
      endcase
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (regRd) begin
      case (regAddr)
        SSP_OFF_MODE: rdata_q <= mode_q;
        SSP_OFF_DATA_LO: rdata_q <= dataLo_q;
        SSP_OFF_DATA_HI: rdata_q <= dataHi_q;
        SSP_OFF_PORT: rdata_q <= port_q;
        SSP_OFF_PINSEL: rdata_q <= pinsel_q;
        SSP_OFF_PORTC: rdata_q <= portc_q;
        SSP_OFF_IRQ: rdata_q <= {7'h00, irqFlag_q};
        SSP_OFF_IEN: rdata_q <= {7'h00, irqEn_q};
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end
  assign regRdata = rdata_q;
  // ********************************************
  // pin drivers
  // ********************************************
  assign sckOut = sckLvl_q;
  assign sckOe = pinClk && !extClk;
  assign sdoOut = sdo_q;
  // open-drain: only drive low when pull-up disabled
  assign sdoOe = pinOut && (!portc_q[SSP_PORTC_PUDIS] || !sdo_q);
  // ********************************************
  // checks
  // ********************************************
  start_ignores_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == SSP_START_PEND && !modeWr) |=> $stable(cnt_q) && cnt_q == 5'h00)
    else $error("counter moved in start pending");
  write_restarts_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    modeWr |=> state_q == SSP_START_PEND && cnt_q == 5'h00)
    else $error("mode write did not restart");
  dummy_pend_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (dummyRd && !modeWr && state_q == SSP_START_PEND) |=> state_q == SSP_CLK_PEND)
    else $error("dummy read did not arm");
  exit_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    xferExit |=> irqFlag_q && cnt_q == 5'h00)
    else $error("exit without flag");
  abort_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == SSP_XFER && dummyRd && !modeWr) |=> state_q == SSP_CLK_PEND)
    else $error("dummy read did not abort");
  cont_noxfer_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    contClk |-> state_q != SSP_XFER || !$past(contClk))
    else $error("transfer in continuous clock mode");
  count_limit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cnt_q < wordLen)
    else $error("counter beyond word length");
  irq_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    xferExit |=> irqReq == irqEn_q)
    else $error("request not gated by enable");
  sdo_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    1'b1 |=> sdoOut == $past(port_q[SSP_PORT_IDLE]))
    else $error("data out not idle level");
  // transfer start: an armed controller sees its first falling serial clock
  sequence armed_fall_s;
    state_q == SSP_CLK_PEND && active && sckFall && !modeWr;
  endsequence
  sequence in_xfer_s;
    state_q == SSP_XFER;
  endsequence
  first_clock_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    armed_fall_s |=> in_xfer_s)
    else $error("first clock did not start transfer");
  xfer_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == SSP_XFER && modeWr) |=> state_q == SSP_START_PEND && cnt_q == 5'h00 && irqFlag_q)
    else $error("mode write in transfer did not restart");
  clock_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!intDrive && sckLvl_q) |=> sckLvl_q)
    else $error("clock moved while not running");
  sck_stop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (done && !extClk) |=> sckLvl_q && !intRun_q)
    else $error("internal clock did not stop");
  narrow_upper_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (shiftNow && !wide) |=> $stable(dataHi_q))
    else $error("upper data shifted in 8-bit mode");
  lsb_first_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (active && sckFall) |=> port_q[SSP_PORT_IDLE] == $past(dataLo_q[0]))
    else $error("data out not least significant bit");
endmodule : ssp_core
`default_nettype wire

//--- rtl/ssp_if.sv
// interface carrying the pin-side signals between core and pin synchroniser
// assumes both ends run on ref_clk
`timescale 1ns/1ps
`default_nettype none
interface ssp_if;
  logic sckSync;
  logic sdiSync;
  modport sync (output sckSync, output sdiSync);
  modport core (input sckSync, input sdiSync);
endinterface : ssp_if
`default_nettype wire

//--- rtl/ssp_pin_sync.sv
// two-flop synchronisers for the serial clock and data-in pins
// assumes pins are asynchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
module ssp_pin_sync (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // pins
  input wire logic sckIn,
  input wire logic sdiIn,
  // synchronised side
  ssp_if.sync pins
);
  logic [1:0] sck_q;
  logic [1:0] sdi_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_q <= 2'h3;
      sdi_q <= 2'h0;
    end else begin
      sck_q <= {sck_q[0], sckIn};
      sdi_q <= {sdi_q[0], sdiIn};
    end
  end
  assign pins.sckSync = sck_q[1];
  assign pins.sdiSync = sdi_q[1];
endmodule : ssp_pin_sync
`default_nettype wire

//--- rtl/ssp_pkg.sv
// package for the 8/16-bit synchronous serial port: register map, field layout, modes
// assumes an 8-bit register port and a 125 MHz ref_clk
package ssp_pkg;
  // ********************************************
  // register offsets
  // ********************************************
  localparam logic [3:0] SSP_OFF_MODE = 4'h0;
  localparam logic [3:0] SSP_OFF_DATA_LO = 4'h1;
  localparam logic [3:0] SSP_OFF_DATA_HI = 4'h2;
  localparam logic [3:0] SSP_OFF_PORT = 4'h3;
  localparam logic [3:0] SSP_OFF_PINSEL = 4'h4;
  localparam logic [3:0] SSP_OFF_PORTC = 4'h5;
  localparam logic [3:0] SSP_OFF_IRQ = 4'h6;
  localparam logic [3:0] SSP_OFF_IEN = 4'h7;
  // ********************************************
  // field positions
  // ********************************************
  localparam int SSP_MODE_WIDTH = 6;
  localparam int SSP_MODE_ENHI = 5;
  localparam int SSP_MODE_ENLO = 4;
  localparam int SSP_MODE_CKSRC = 0;
  localparam int SSP_PORT_IDLE = 7;
  localparam int SSP_PIN_OUT = 3;
  localparam int SSP_PIN_IN = 2;
  localparam int SSP_PIN_CLK = 1;
  localparam int SSP_PORTC_PUDIS = 3;
  localparam int SSP_IRQ_BIT = 0;
  // ********************************************
  // reset values and constants
  // ********************************************
  localparam logic [7:0] SSP_RST_MODE = 8'h00;
  localparam logic [7:0] SSP_RST_PINSEL = 8'h00;
  localparam logic [7:0] SSP_RST_PORTC = 8'h97;
  localparam logic [3:0] SSP_CKSRC_EXT = 4'hf;
  localparam int SSP_PRESC_W = 8;
  localparam int SSP_NTAPS = 8;
  typedef enum logic [1:0] {SSP_START_PEND, SSP_CLK_PEND, SSP_XFER} ssp_state_t;
endpackage : ssp_pkg

//--- tb/ssp_peer_model.sv
// behavioural far-side serial peer: sends on sdi, captures sdo, clocks bursts when asked
// assumes the bench resolves the clock line with a pull-up when nobody drives it
`timescale 1ns/1ps
`default_nettype none
module ssp_peer_model (
  // link pins
  input wire logic sckLine,
  input wire logic sdoLine,
  output logic sdiOut,
  output logic sckDrv,
  output logic sckDrvOe,
  // bench control
  input wire logic arm,
  input wire logic burstGo,
  input wire logic [4:0] burstLen,
  input wire logic [15:0] txWord,
  output logic [15:0] rxWord,
  output logic [15:0] riseCnt,
  output logic busy
);
  logic [15:0] txSh;
  initial begin
    sdiOut = 1'b0;
    sckDrv = 1'b1;
    sckDrvOe = 1'b0;
    busy = 1'b0;
  end
  always @(posedge arm) begin
    txSh = txWord;
    rxWord = 16'h0000;
    riseCnt = 16'h0000;
  end
  // 125 ns clock period burst, idle high, line released between frames
  always @(posedge burstGo) begin
    busy = 1'b1;
    sckDrvOe = 1'b1;
    repeat (burstLen) begin
      #62.5 sckDrv = 1'b0;
      #62.5 sckDrv = 1'b1;
    end
    #62.5 sckDrvOe = 1'b0;
    busy = 1'b0;
  end
  always @(negedge sckLine) begin
    sdiOut = txSh[0];
    txSh = {1'b0, txSh[15:1]};
  end
  // receive: sample data-out on each rising clock; sdi holds until the next fall
  always @(posedge sckLine) begin
    rxWord = {sdoLine, rxWord[15:1]};
    riseCnt = riseCnt + 16'h0001;
  end
endmodule : ssp_peer_model
`default_nettype wire

//--- tb/test_sync_serial_8_16_port.sv
// self-checking bench for the serial port core through its register port
// assumes ssp_pkg offsets and a peer model on the serial pins
`timescale 1ns/1ps
`default_nettype none
module test_sync_serial_8_16_port;
  import ssp_pkg::*;
  logic ref_clk, rst_n, regWr, regRd, sckOut, sckOe, sdoOut, sdoOe, irqReq;
  logic [3:0] regAddr;
  logic [7:0] regWdata, regRdata, rv;
  logic sckLine, sdoLine, sdiLine, peerSck, peerOe, arm, burstGo, busy;
  logic [4:0] burstLen;
  logic [15:0] txWord, rxWord, riseCnt;
  int fail_count, checks;
  logic [3:0] rstAddr [6] = '{SSP_OFF_MODE, SSP_OFF_PINSEL, SSP_OFF_PORTC, SSP_OFF_IRQ,
    SSP_OFF_IEN, 4'h8};
  logic [7:0] rstVal [6] = '{SSP_RST_MODE, SSP_RST_PINSEL, SSP_RST_PORTC, 8'h00, 8'h00, 8'h00};
  assign sckLine = sckOe ? sckOut : (peerOe ? peerSck : 1'b1);
  assign sdoLine = sdoOe ? sdoOut : 1'b1;
  ssp_core #(.PRESC_W(8)) u_ssp_core (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sckIn(sckLine),
    .sckOut(sckOut), .sckOe(sckOe), .sdiIn(sdiLine), .sdoOut(sdoOut), .sdoOe(sdoOe),
    .irqReq(irqReq));
  ssp_peer_model u_ssp_peer_model (.sckLine(sckLine), .sdoLine(sdoLine), .sdiOut(sdiLine),
    .sckDrv(peerSck), .sckDrvOe(peerOe), .arm(arm), .burstGo(burstGo), .burstLen(burstLen),
    .txWord(txWord), .rxWord(rxWord), .riseCnt(riseCnt), .busy(busy));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // ****************************************
  // access and compare tasks
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    d = regRdata;
  endtask : rd
  task automatic chkv(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chkv
  task automatic chkb(input string n, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, g);
    end
  endtask : chkb
  task automatic armPeer(input logic [15:0] tx);
    @(posedge ref_clk);
    txWord <= tx;
    arm <= 1'b1;
    @(posedge ref_clk);
    arm <= 1'b0;
    #1;
  endtask : armPeer
  task automatic burst(input logic [4:0] n);
    @(posedge ref_clk);
    burstLen <= n;
    burstGo <= 1'b1;
    @(posedge ref_clk);
    burstGo <= 1'b0;
    for (int i = 0; i < 4000 && busy !== 1'b0; i++) @(posedge ref_clk);
    tick(20);
  endtask : burst
  task automatic waitIrq();
    for (int i = 0; i < 1000 && irqReq !== 1'b1; i++) @(posedge ref_clk);
    #1;
  endtask : waitIrq
  task automatic results();
    if (fail_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    results();
  end
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    {regWr, regRd, arm, burstGo} = 4'h0;
    regAddr = 4'h0;
    regWdata = 8'h00;
    burstLen = 5'h00;
    txWord = 16'h0000;
    fail_count = 0;
    checks = 0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    tick(1);
    chkb("sckOut reset", 1'b1, sckOut);
    chkb("sckOe reset", 1'b0, sckOe);
    for (int i = 0; i < 6; i++) begin
      rd(rstAddr[i], rv);
      chkv("reset value", {8'h00, rstVal[i]}, {8'h00, rv});
    end
    wr(SSP_OFF_IEN, 8'h01);
    wr(SSP_OFF_PINSEL, 8'h0e);
    wr(SSP_OFF_MODE, 8'h33);
    wr(SSP_OFF_DATA_LO, 8'ha5);
    armPeer(16'h003c);
    rd(SSP_OFF_MODE, rv);
    waitIrq();
    chkb("irq after 8 bits", 1'b1, irqReq);
    chkv("peer rx 8", 16'h00a5, {8'h00, rxWord[15:8]});
    rd(SSP_OFF_DATA_LO, rv);
    chkv("rx lo 8", 16'h003c, {8'h00, rv});
    tick(200);
    chkv("clock count", 16'h0008, riseCnt);
    chkb("sdo last bit", 1'b1, sdoOut);
    chkb("sdoOe cmos", 1'b1, sdoOe);
    wr(SSP_OFF_PORTC, 8'h9f);
    chkb("sdoOe od high", 1'b0, sdoOe);
    wr(SSP_OFF_PORT, 8'h00);
    tick(2);
    chkb("sdo idle", 1'b0, sdoOut);
    chkb("sdoOe od low", 1'b1, sdoOe);
    wr(SSP_OFF_PORTC, SSP_RST_PORTC);
    wr(SSP_OFF_MODE, 8'h7f);
    wr(SSP_OFF_DATA_HI, 8'h12);
    wr(SSP_OFF_DATA_LO, 8'h34);
    wr(SSP_OFF_IRQ, 8'h00);
    chkb("irq cleared", 1'b0, irqReq);
    armPeer(16'hbeef);
    rd(SSP_OFF_MODE, rv);
    burst(16);
    chkb("irq 16 bits", 1'b1, irqReq);
    chkb("sckOe ext", 1'b0, sckOe);
    chkv("peer rx 16", 16'h1234, rxWord);
    rd(SSP_OFF_DATA_HI, rv);
    chkv("rx hi 16", 16'h00be, {8'h00, rv});
    rd(SSP_OFF_DATA_LO, rv);
    chkv("rx lo 16", 16'h00ef, {8'h00, rv});
    wr(SSP_OFF_IRQ, 8'h00);
    armPeer(16'h0000);
    burst(16);
    chkv("resumed rx", 16'hbeef, rxWord);
    chkb("irq resumed", 1'b1, irqReq);
    wr(SSP_OFF_IRQ, 8'h00);
    rd(SSP_OFF_MODE, rv);
    burst(3);
    chkb("no irq mid word", 1'b0, irqReq);
    rd(SSP_OFF_MODE, rv);
    tick(3);
    chkb("abort irq", 1'b1, irqReq);
    wr(SSP_OFF_IRQ, 8'h00);
    burst(3);
    wr(SSP_OFF_MODE, 8'h7f);
    tick(3);
    chkb("mode write irq", 1'b1, irqReq);
    wr(SSP_OFF_IEN, 8'h00);
    chkb("masked", 1'b0, irqReq);
    rd(SSP_OFF_IRQ, rv);
    chkv("flag held", 16'h0001, {8'h00, rv});
    wr(SSP_OFF_IRQ, 8'h00);
    wr(SSP_OFF_IEN, 8'h01);
    wr(SSP_OFF_MODE, 8'h7f);
    wr(SSP_OFF_DATA_LO, 8'h5a);
    burst(16);
    chkb("start pending irq", 1'b0, irqReq);
    rd(SSP_OFF_DATA_LO, rv);
    chkv("no shift", 16'h005a, {8'h00, rv});
    wr(SSP_OFF_PINSEL, 8'h0a);
    wr(SSP_OFF_MODE, 8'h33);
    wr(SSP_OFF_DATA_LO, 8'hc3);
    armPeer(16'hffff);
    rd(SSP_OFF_MODE, rv);
    waitIrq();
    chkv("tx only peer", 16'h00c3, {8'h00, rxWord[15:8]});
    rd(SSP_OFF_DATA_LO, rv);
    chkv("tx only rx", 16'h0000, {8'h00, rv});
    wr(SSP_OFF_IRQ, 8'h00);
    wr(SSP_OFF_PINSEL, 8'h02);
    wr(SSP_OFF_MODE, 8'h03);
    armPeer(16'h0000);
    rd(SSP_OFF_MODE, rv);
    tick(700);
    chkb("free clock", 1'b1, riseCnt > 16'd16);
    chkb("never transfers", 1'b0, irqReq);
    results();
  end
endmodule : test_sync_serial_8_16_port
`default_nettype wire
